// File: rsbd_core_model.sv
// core model issuing register and external load accesses
`timescale 1ns/10ps
module rsbd_core_model (
  input wire logic mclk, // clock
  input wire logic [7:0] rdata, // read data
  output logic reg_rd, // read
  output logic reg_wr, // write
  output logic short_addr, // short form
  output logic indirect, // indirect
  output logic ext_load, // ext ram
  output logic [7:0] reg_addr, // address
  output logic [15:0] ext_addr, // ext address
  output logic [7:0] wdata // data out
);
  initial begin
    {reg_rd, reg_wr, short_addr, indirect, ext_load} = 5'h00;
    reg_addr = 8'h00;
    ext_addr = 16'h0000;
    wdata = 8'h00;
  end
  // ext ram only through external load, never stack or code
  task automatic op(input logic wr, sh, ind, ext, input logic [15:0] a,
                    input logic [7:0] d, output logic [7:0] q);
    @(negedge mclk);
    reg_wr = wr;
    reg_rd = !wr;
    short_addr = sh;
    indirect = ind;
    ext_load = ext;
    reg_addr = a[7:0];
    ext_addr = a;
    wdata = d;
    @(negedge mclk);
    q = rdata;
    {reg_rd, reg_wr, ext_load} = 3'h0;
    // released lines float: show inverse rather than a stale value
    reg_addr = ~reg_addr;
    ext_addr = ~ext_addr;
    wdata = ~wdata;
  endtask : op
endmodule : rsbd_core_model

// File: rsbd_decode.sv
// register space decoder: pointer, expanded groups, extended ram, reset
// How it works
// - pointer high nibble picks working group for short addresses
// - pointer low nibble picks expanded group for addresses 0 to 15
// - low nibble zero reaches file; other values swap in expanded group
// - only groups D and F exist; timer controls are in group D
// - pointer sits at 253; pointer zero maps ports to registers 0-3
// - group D maps timer controls 0-2 at 0-2, register 3 reserved
// - short addressing splits the file in sixteen groups of sixteen
// - ports at 0-3, general 4-239, control 240-255
// - E0 to EF of bank 0 not reachable by direct address
// - full 8-bit and short 4-bit register addresses both accepted
// - extended ram FF00-FFFF, reached only by external load
// - first twelve program bytes are six interrupt vectors, 16 KB rom
// - fetch starts at 000C five to ten clock periods after reset
// - 8-bit stack pointer at 255, stack in lower general registers
// - stack pointer high byte is ordinary register with internal stack
// - stack access copies high byte onto port 0 in address mode
// - reset from power-on, watchdog, stop recovery or low voltage
// - power-on and watchdog resets hold internal reset for por time
// - stop recovery keeps watchdog, stop, port2 and port3 modes
`timescale 1ns/10ps
`include "rsbd_defines.svh"
module rsbd_decode import rsbd_pkg::*; #(
  parameter int POR_CYCLES = `RSBD_POR_CYCLES
) (
  input wire logic mclk, // system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic ce, // clock enable
  input wire logic reg_rd, // register read strobe
  input wire logic reg_wr, // register write strobe
  input wire logic short_addr, // address is a 4-bit working address
  input wire logic [7:0] reg_addr, // register address
  input wire logic indirect, // access is indirect
  input wire logic ext_load, // external load to extended ram
  input wire logic [15:0] ext_addr, // external load address
  input wire logic stack_acc, // internal stack access
  input wire logic [7:0] wdata, // write data
  input wire logic [7:0] port_in [0:3], // port pin values
  input wire logic por_evt, // power-on reset cause
  input wire logic wdt_evt, // watchdog expiry cause
  input wire logic smr_evt, // stop-mode recovery cause
  input wire logic lvd_evt, // low voltage cause
  input wire logic [15:0] fetch_addr, // core instruction fetch address
  output logic [7:0] rdata, // read data
  output logic access_err, // access refused
  output logic [7:0] port_out [0:3], // port output registers
  output logic [7:0] timer_ctrl [0:2], // timer controls 0-2
  output logic [7:0] register_pointer, // pointer value
  output logic [15:0] stack_ptr, // stack pointer high and low
  output logic [7:0] watchdog_mode_reg, // watchdog mode
  output logic [7:0] stop_recovery_mode_reg, // stop recovery mode
  output logic [7:0] port2_mode_reg, // port 2 mode
  output logic [7:0] port3_mode_reg, // port 3 mode
  output logic core_rst_n, // internal reset, active low
  output logic fetch_start, // pulse: begin fetching
  output logic [15:0] start_addr, // first fetch address
  output logic fetch_is_vector // fetch falls in the vector area
);
  rsbd_ram_if rf ();
  rsbd_ram_if xr ();
  rsbd_ram u_rf (.mclk(mclk), .ce(ce), .bus(rf.mem));
  rsbd_ram u_xr (.mclk(mclk), .ce(ce), .bus(xr.mem));

  logic [7:0] register_pointer_reg;
  logic [7:0] stack_pointer_high_reg;
  logic [7:0] stack_pointer_low_reg;
  logic [7:0] port_reg [0:3];
  logic [7:0] ctl_reg [0:2];
  logic [7:0] grp_f_reg [0:15];
  logic [7:0] watchdog_mode_reg_reg;
  logic [7:0] smr_reg;
  logic [7:0] p2m_reg;
  logic [7:0] p3m_reg;
  logic [7:0] p01m_reg;
  rsbd_rst_e rst_state_reg;
  logic [31:0] rst_cnt_reg;
  logic [2:0] start_cnt_reg;
  logic fetch_start_reg;
  logic [7:0] rdata_reg;
  logic err_reg;

  // effective 8-bit address after working group substitution
  function automatic logic [7:0] eff_addr(input logic short_a,
      input logic [7:0] a, input logic [7:0] rp);
    if (short_a) begin
      eff_addr = {rp[`RSBD_WG_HI:`RSBD_WG_LO], a[3:0]};
    end else if (a[7:4] == `RSBD_SHORT_PREFIX) begin
      eff_addr = {rp[`RSBD_WG_HI:`RSBD_WG_LO], a[3:0]};
    end else begin
      eff_addr = a;
    end
  endfunction : eff_addr

  // group D slots 0-2 hold timer controls; slot 3 up is reserved
  function automatic logic ctl_slot(input logic [3:0] g,
      input logic [7:0] a);
    ctl_slot = (g == `RSBD_GROUP_D) && (a[3:0] < 4'h3);
  endfunction : ctl_slot

  logic [7:0] ea;
  logic [3:0] grp;
  logic low16;
  logic direct_e;
  logic hit_ok;
  logic xr_hit;
  assign ea = eff_addr(short_addr, reg_addr, register_pointer_reg);
  assign grp = register_pointer_reg[`RSBD_EG_HI:`RSBD_EG_LO];
  assign low16 = (ea[7:4] == 4'h0) && (grp != `RSBD_NORMAL_GROUP);
  // the E-prefix form is the short form, so bank E is never direct
  assign direct_e = !short_addr && !indirect &&
      (reg_addr[7:4] == `RSBD_NODIRECT_HI);
  assign hit_ok = !direct_e;
  assign xr_hit = ext_load && (ext_addr[15:8] == `RSBD_XRAM_PAGE);
  logic ctl_hit;
  logic refuse;
  assign ctl_hit = ctl_slot(grp, ea);
  // refused reads return zero so no stale byte leaks out
  assign refuse = direct_e && !ext_load;

  assign rf.addr = ea;
  assign rf.wdata = wdata;
  // the low four and the control bytes live in flops, not in the ram
  assign rf.we = reg_wr && hit_ok && !ext_load && !low16 &&
      (ea >= `RSBD_GP_LO) && (ea < `RSBD_CTRL_LO);
  assign xr.addr = ext_addr[7:0];
  assign xr.wdata = wdata;
  assign xr.we = reg_wr && xr_hit;

  // writes under an external load belong to the extended ram alone
  logic wr_go;
  assign wr_go = ce && reg_wr && hit_ok && !ext_load;

  always_ff @(posedge mclk) begin
    if (srst) begin
      register_pointer_reg <= 8'h00;
    end else if (wr_go && ea == `RSBD_ADDR_RP) begin
      register_pointer_reg <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      stack_pointer_low_reg <= 8'h00;
      stack_pointer_high_reg <= 8'h00;
    end else if (wr_go && ea == `RSBD_ADDR_SPL) begin
      stack_pointer_low_reg <= wdata;
    end else if (wr_go && ea == `RSBD_ADDR_SPH) begin
      stack_pointer_high_reg <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < 4; i++) port_reg[i] <= 8'h00;
    end else if (ce) begin
      // a direct port write wins over the stack copy in the same cycle
      if (wr_go && !low16 && ea < `RSBD_GP_LO) begin
        port_reg[ea[1:0]] <= wdata;
      end else if (stack_acc && p01m_reg[`RSBD_P01M_ADDR_MODE]) begin
        port_reg[0] <= stack_pointer_high_reg;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < 3; i++) ctl_reg[i] <= 8'h00;
      for (int j = 0; j < 16; j++) grp_f_reg[j] <= 8'h00;
    end else if (wr_go && low16) begin
      if (ctl_hit) begin
        ctl_reg[ea[1:0]] <= wdata;
      end else if (grp == `RSBD_GROUP_F) begin
        grp_f_reg[ea[3:0]] <= wdata;
      end
      // other groups drop the write
    end
  end

  // watchdog, stop, port2 and port3 modes are cleared only by the non-recovery resets
  logic hard_rst;
  assign hard_rst = srst && !smr_evt;
  always_ff @(posedge mclk) begin
    if (hard_rst) begin
      watchdog_mode_reg_reg <= 8'h00;
      smr_reg <= 8'h00;
      p2m_reg <= 8'h00;
      p3m_reg <= 8'h00;
    end else if (wr_go && !srst) begin
      if (ea == `RSBD_ADDR_WATCHDOG_MODE_REG) watchdog_mode_reg_reg <= wdata;
      if (ea == `RSBD_ADDR_SMR) smr_reg <= wdata;
      if (ea == `RSBD_ADDR_P2M) p2m_reg <= wdata;
      if (ea == `RSBD_ADDR_P3M) p3m_reg <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      p01m_reg <= 8'h00;
    end else if (wr_go && ea == `RSBD_ADDR_P01M) begin
      p01m_reg <= wdata;
    end
  end

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (xr_hit) begin
      rd_mux = xr.rdata;
    end else if (low16) begin
      if (ctl_hit) begin
        rd_mux = ctl_reg[ea[1:0]];
      end else if (grp == `RSBD_GROUP_F) begin
        rd_mux = grp_f_reg[ea[3:0]];
      end else begin
        rd_mux = 8'h00;
      end
    end else if (ea < `RSBD_GP_LO) begin
      // ports read back the pins, not the output latches
      rd_mux = port_in[ea[1:0]];
    end else if (ea < `RSBD_CTRL_LO) begin
      rd_mux = rf.rdata;
    end else begin
      case (ea)
        `RSBD_ADDR_RP: rd_mux = register_pointer_reg;
        `RSBD_ADDR_SPH: rd_mux = stack_pointer_high_reg;
        `RSBD_ADDR_SPL: rd_mux = stack_pointer_low_reg;
        `RSBD_ADDR_WATCHDOG_MODE_REG: rd_mux = watchdog_mode_reg_reg;
        `RSBD_ADDR_SMR: rd_mux = smr_reg;
        `RSBD_ADDR_P2M: rd_mux = p2m_reg;
        `RSBD_ADDR_P3M: rd_mux = p3m_reg;
        `RSBD_ADDR_P01M: rd_mux = p01m_reg;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_reg <= 8'h00;
      err_reg <= 1'b0;
    end else if (ce) begin
      err_reg <= (reg_rd || reg_wr) && refuse;
      if (reg_rd) begin
        rdata_reg <= refuse ? 8'h00 : rd_mux;
      end
    end
  end

  // internal reset sequencer; por count is long so it is a parameter
  logic any_src;
  logic long_src;
  assign any_src = por_evt || wdt_evt || smr_evt || lvd_evt;
  assign long_src = por_evt || wdt_evt;
  always_ff @(posedge mclk) begin
    if (srst) begin
      rst_state_reg <= RSBD_ST_WAIT;
      rst_cnt_reg <= 32'd0;
      start_cnt_reg <= 3'h0;
      fetch_start_reg <= 1'b0;
    end else if (ce) begin
      fetch_start_reg <= 1'b0;
      case (rst_state_reg)
        RSBD_ST_RUN: begin
          if (any_src) begin
            rst_state_reg <= long_src ? RSBD_ST_HOLD : RSBD_ST_WAIT;
            rst_cnt_reg <= 32'd0;
            start_cnt_reg <= 3'h0;
          end
        end
        RSBD_ST_HOLD: begin
          if (rst_cnt_reg >= POR_CYCLES - 1) begin
            rst_state_reg <= RSBD_ST_WAIT;
          end
          rst_cnt_reg <= rst_cnt_reg + 32'd1;
        end
        RSBD_ST_WAIT: begin
          start_cnt_reg <= start_cnt_reg + 3'h1;
          // release and fetch pulse share one edge so the core never runs early
          if (start_cnt_reg == `RSBD_START_DLY - 3'h1) begin
            rst_state_reg <= RSBD_ST_RUN;
            fetch_start_reg <= 1'b1;
          end
        end
        default: rst_state_reg <= RSBD_ST_WAIT;
      endcase
    end
  end

  assign rdata = rdata_reg;
  assign access_err = err_reg;
  assign port_out = port_reg;
  assign timer_ctrl = ctl_reg;
  assign register_pointer = register_pointer_reg;
  assign stack_ptr = {stack_pointer_high_reg, stack_pointer_low_reg};
  assign watchdog_mode_reg = watchdog_mode_reg_reg;
  assign stop_recovery_mode_reg = smr_reg;
  assign port2_mode_reg = p2m_reg;
  assign port3_mode_reg = p3m_reg;
  assign core_rst_n = (rst_state_reg == RSBD_ST_RUN);
  assign fetch_start = fetch_start_reg;
  assign start_addr = `RSBD_START_ADDR;
  assign fetch_is_vector = (fetch_addr < `RSBD_VECT_END) &&
      (fetch_addr < `RSBD_ROM_LIMIT);
endmodule : rsbd_decode

// File: rsbd_decode_chk.sv
// port assertions for the register space decoder
`timescale 1ns/10ps
module rsbd_decode_chk #(
  parameter int POR_CYCLES = 20
) (
  input wire logic mclk, // clock
  input wire logic srst, // reset
  input wire logic ce, // enable
  input wire logic reg_rd, // read
  input wire logic reg_wr, // write
  input wire logic short_addr, // short form
  input wire logic [7:0] reg_addr, // address
  input wire logic indirect, // indirect
  input wire logic ext_load, // ext ram
  input wire logic [7:0] wdata, // data in
  input wire logic por_evt, // power-on
  input wire logic smr_evt, // stop recovery
  input wire logic [15:0] fetch_addr, // fetch
  input wire logic access_err, // refused
  input wire logic [7:0] timer_ctrl [0:2], // timers
  input wire logic [7:0] register_pointer, // pointer
  input wire logic [7:0] watchdog_mode_reg, // mode
  input wire logic [7:0] stop_recovery_mode_reg, // mode
  input wire logic [7:0] port2_mode_reg, // mode
  input wire logic [7:0] port3_mode_reg, // mode
  input wire logic core_rst_n, // core reset
  input wire logic fetch_start, // fetch pulse
  input wire logic [15:0] start_addr, // start
  input wire logic fetch_is_vector // vector area
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic keep_reg;
  logic wipe_reg;
  wire take = ce && (reg_rd || reg_wr) && !ext_load;
  wire direct = !short_addr && !indirect;
  // remembers which kind of reset just ended
  always_ff @(posedge mclk) begin
    keep_reg <= srst && smr_evt;
    wipe_reg <= srst && !smr_evt;
  end
  sequence s_release; $fell(srst); endsequence
  sequence s_launch; !core_rst_n [*3] ##[1:7] fetch_start; endsequence
  a_ptr_write: assert property (take && reg_wr && direct &&
    reg_addr == 8'hFD |=> register_pointer == $past(wdata))
    else $error("pointer write lost");
  a_timer_write: assert property (take && reg_wr && direct &&
    register_pointer[3:0] == 4'hD && reg_addr == 8'h01
    |=> timer_ctrl[1] == $past(wdata)) else $error("timer control lost");
  a_direct_err: assert property (take && direct &&
    reg_addr[7:4] == 4'hE |=> access_err) else $error("no refusal");
  a_no_err: assert property (take && reg_addr[7:4] != 4'hE
    |=> !access_err) else $error("false refusal");
  a_vector_area: assert property (fetch_is_vector ==
    (fetch_addr < 16'h000C)) else $error("vector flag wrong");
  a_start_const: assert property (start_addr == 16'h000C)
    else $error("start address wrong");
  a_start_wait: assert property (s_release |-> s_launch)
    else $error("fetch start timing");
  a_core_up: assert property ($rose(core_rst_n) |-> fetch_start)
    else $error("core released without fetch");
  a_por_hold: assert property (por_evt |=> !core_rst_n [*8])
    else $error("power-on reset too short");
  a_smr_keep: assert property (keep_reg |->
    watchdog_mode_reg == $past(watchdog_mode_reg) &&
    stop_recovery_mode_reg == $past(stop_recovery_mode_reg) &&
    port2_mode_reg == $past(port2_mode_reg) &&
    port3_mode_reg == $past(port3_mode_reg)) else $error("mode lost");
  a_full_wipe: assert property (wipe_reg |->
    watchdog_mode_reg == 8'h00 && port3_mode_reg == 8'h00)
    else $error("mode kept by full reset");
endmodule : rsbd_decode_chk
bind rsbd_decode rsbd_decode_chk #(.POR_CYCLES(POR_CYCLES)) chk (.mclk,
  .srst, .ce, .reg_rd, .reg_wr, .short_addr, .reg_addr, .indirect,
  .ext_load, .wdata, .por_evt, .smr_evt, .fetch_addr, .access_err,
  .timer_ctrl, .register_pointer, .watchdog_mode_reg,
  .stop_recovery_mode_reg, .port2_mode_reg, .port3_mode_reg, .core_rst_n,
  .fetch_start, .start_addr, .fetch_is_vector);

// File: rsbd_decode_tb.sv
// self-checking bench for the register space decoder
`timescale 1ns/10ps
module rsbd_decode_tb;
  logic mclk, srst, ce, stack_acc, por_evt, wdt_evt, smr_evt, lvd_evt;
  logic reg_rd, reg_wr, short_addr, indirect, ext_load;
  logic access_err, core_rst_n, fetch_start, fetch_is_vector;
  logic [7:0] reg_addr, wdata, rdata, register_pointer, q;
  logic [15:0] ext_addr, fetch_addr, stack_ptr, start_addr;
  logic [7:0] port_in [0:3];
  logic [7:0] port_out [0:3];
  logic [7:0] timer_ctrl [0:2];
  logic [7:0] watchdog_mode_reg, stop_recovery_mode_reg;
  logic [7:0] port2_mode_reg, port3_mode_reg;
  int bad_count, comparisons, cyc, n;
  rsbd_decode #(.POR_CYCLES(20)) uut (.mclk, .srst, .ce, .reg_rd, .reg_wr,
    .short_addr, .reg_addr, .indirect, .ext_load, .ext_addr, .stack_acc,
    .wdata, .port_in, .por_evt, .wdt_evt, .smr_evt, .lvd_evt, .fetch_addr,
    .rdata, .access_err, .port_out, .timer_ctrl, .register_pointer,
    .stack_ptr, .watchdog_mode_reg, .stop_recovery_mode_reg,
    .port2_mode_reg, .port3_mode_reg, .core_rst_n, .fetch_start,
    .start_addr, .fetch_is_vector);
  rsbd_core_model m (.mclk, .rdata, .reg_rd, .reg_wr, .short_addr,
    .indirect, .ext_load, .reg_addr, .ext_addr, .wdata);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    m.op(1'b1, 1'b0, 1'b0, 1'b0, {8'h00, a}, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    m.op(1'b0, 1'b0, 1'b0, 1'b0, {8'h00, a}, 8'h00, q);
  endtask : rd
  task automatic wait_up();
    for (n = 0; n < 60 && core_rst_n !== 1'b1; n++) @(negedge mclk);
  endtask : wait_up
  task automatic t_reset(input logic keep);
    @(negedge mclk);
    srst = 1'b1;
    smr_evt = keep;
    @(negedge mclk);
    {srst, smr_evt} = 2'b00;
    wait_up();
    chk(n >= 5 && n <= 10, 1'b1);
  endtask : t_reset
  task automatic t_groups();
    wr(8'hFD, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(i[7:0]);
      chk(q, port_in[i]);
    end
    wr(8'hFD, 8'h0D);
    for (int i = 0; i < 3; i++) begin
      wr(i[7:0], 8'hD0 + i[7:0]);
      chk(timer_ctrl[i], 8'hD0 + i[7:0]);
    end
    rd(8'h03);
    chk(q, 8'h00);
    m.op(1'b0, 1'b1, 1'b0, 1'b0, 16'h0001, 8'h00, q);
    chk(q, 8'hD1);
    wr(8'hFD, 8'h0F);
    wr(8'h00, 8'h66);
    rd(8'h00);
    chk(q, 8'h66);
    chk(timer_ctrl[0], 8'hD0);
    foreach (port_in[g]) begin
      wr(8'hFD, 8'h01 + 8'h03 * g[7:0]);
      wr(8'h00, 8'h99);
      rd(8'h00);
      chk(q, 8'h00);
    end
  endtask : t_groups
  task automatic t_working();
    wr(8'hFD, 8'h70);
    m.op(1'b1, 1'b1, 1'b0, 1'b0, 16'h0001, 8'h5A, q);
    wr(8'hFD, 8'h7D);
    rd(8'h71);
    chk(q, 8'h5A);
    wr(8'hFD, 8'hE0);
    m.op(1'b1, 1'b1, 1'b0, 1'b0, 16'h0003, 8'h12, q);
    rd(8'hE3);
    chk({access_err, q}, 9'h100);
    m.op(1'b0, 1'b1, 1'b0, 1'b0, 16'h0003, 8'h00, q);
    chk({access_err, q}, 9'h012);
    m.op(1'b1, 1'b0, 1'b0, 1'b1, 16'hFF10, 8'hA5, q);
    m.op(1'b1, 1'b0, 1'b0, 1'b1, 16'hFFFF, 8'h5C, q);
    m.op(1'b0, 1'b0, 1'b0, 1'b1, 16'hFF10, 8'h00, q);
    chk(q, 8'hA5);
    m.op(1'b0, 1'b0, 1'b0, 1'b1, 16'hFFFF, 8'h00, q);
    chk(q, 8'h5C);
  endtask : t_working
  task automatic t_stack();
    wr(8'hFF, 8'h40);
    wr(8'hFE, 8'h9C);
    chk(stack_ptr, 16'h9C40);
    wr(8'hF8, 8'h02);
    stack_acc = 1'b1;
    @(negedge mclk);
    stack_acc = 1'b0;
    @(negedge mclk);
    chk(port_out[0], 8'h9C);
  endtask : t_stack
  task automatic t_cause(input logic [2:0] src);
    {por_evt, wdt_evt, lvd_evt} = src;
    @(negedge mclk);
    {por_evt, wdt_evt, lvd_evt} = 3'b000;
    wait_up();
  endtask : t_cause
  task automatic t_freeze();
    rd(8'h00);
    ce = 1'b0;
    wr(8'hFD, 8'h55);
    rd(8'h01);
    ce = 1'b1;
    chk(register_pointer, 8'h00);
    chk(q, 8'h3C);
  endtask : t_freeze
  task automatic t_modes();
    wr(8'hF1, 8'h3C);
    wr(8'hF7, 8'h0A);
    t_reset(1'b1);
    chk({watchdog_mode_reg, port3_mode_reg}, 16'h3C0A);
    t_reset(1'b0);
    chk({watchdog_mode_reg, port3_mode_reg}, 16'h0000);
    t_cause(3'b100);
    chk(n >= 20, 1'b1);
    t_cause(3'b010);
    chk(n >= 20, 1'b1);
    t_cause(3'b001);
    chk(n >= 5 && n <= 10, 1'b1);
  endtask : t_modes
  task automatic t_vector();
    fetch_addr = 16'h000B;
    @(negedge mclk);
    chk(fetch_is_vector, 1'b1);
    fetch_addr = 16'h000C;
    @(negedge mclk);
    chk(fetch_is_vector, 1'b0);
  endtask : t_vector
  initial begin
    {srst, ce, stack_acc, por_evt, wdt_evt, smr_evt, lvd_evt} = 7'h60;
    fetch_addr = 16'h0100;
    port_in = '{8'h3C, 8'hC3, 8'h5A, 8'hA5};
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    wait_up();
    chk(start_addr, 16'h000C);
    chk(register_pointer, 8'h00);
    t_groups();
    t_working();
    t_stack();
    t_modes();
    t_vector();
    t_freeze();
    print_verdict();
  end
endmodule : rsbd_decode_tb

// File: rsbd_defines.svh
// register space addresses, field positions and reset values
`ifndef RSBD_DEFINES_SVH
`define RSBD_DEFINES_SVH
`define RSBD_ADDR_RP 8'hFD
`define RSBD_ADDR_SPH 8'hFE
`define RSBD_ADDR_SPL 8'hFF
`define RSBD_ADDR_WATCHDOG_MODE_REG 8'hF1
`define RSBD_ADDR_SMR 8'hF2
`define RSBD_ADDR_P2M 8'hF6
`define RSBD_ADDR_P3M 8'hF7
`define RSBD_ADDR_P01M 8'hF8
`define RSBD_WG_HI 7
`define RSBD_WG_LO 4
`define RSBD_EG_HI 3
`define RSBD_EG_LO 0
`define RSBD_GROUP_D 4'hD
`define RSBD_GROUP_F 4'hF
`define RSBD_NORMAL_GROUP 4'h0
`define RSBD_SHORT_PREFIX 4'hE
`define RSBD_NODIRECT_HI 4'hE
`define RSBD_GP_LO 8'h04
`define RSBD_GP_HI 8'hEF
`define RSBD_CTRL_LO 8'hF0
`define RSBD_XRAM_PAGE 8'hFF
`define RSBD_VECT_END 16'h000C
`define RSBD_START_ADDR 16'h000C
`define RSBD_ROM_LIMIT 16'h4000
`define RSBD_START_DLY 3'h5
`define RSBD_POR_CYCLES 32'd200000
`define RSBD_P01M_ADDR_MODE 1
`endif

// File: rsbd_pkg.sv
// types for the register space decoder
package rsbd_pkg;
  typedef logic [7:0] rsbd_byte_t;
  typedef enum logic [1:0] {
    RSBD_ST_RUN = 2'b00,
    RSBD_ST_HOLD = 2'b01,
    RSBD_ST_WAIT = 2'b10
  } rsbd_rst_e;
  typedef enum logic [1:0] {
    RSBD_SRC_NONE = 2'b00,
    RSBD_SRC_POR = 2'b01,
    RSBD_SRC_SMR = 2'b10,
    RSBD_SRC_LVD = 2'b11
  } rsbd_src_e;
endpackage : rsbd_pkg

// File: rsbd_ram.sv
// 256 byte flip-flop storage, one write port and one read port
`timescale 1ns/10ps
module rsbd_ram (
  input wire logic mclk, // clock
  input wire logic ce, // clock enable
  rsbd_ram_if.mem bus // storage port
);
  logic [7:0] mem_reg [0:255];
  always_ff @(posedge mclk) begin
    if (ce && bus.we) begin
      mem_reg[bus.addr] <= bus.wdata;
    end
  end
  assign bus.rdata = mem_reg[bus.addr];
endmodule : rsbd_ram

// File: rsbd_ram_if.sv
// port between the decoder and its byte storage
`timescale 1ns/10ps
interface rsbd_ram_if;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : rsbd_ram_if
